// *** rtl/fte_pkg.sv ***
package fte_pkg;

  // ==========================================================
  // Code-group widths and the nibble word held in the FIFO.
  localparam int NIB_W = 4;
  localparam int CG_W = 5;
  localparam int WORD_W = 6; // {error, enable, nibble}
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_ER_POS = 5;
  localparam int WORD_EN_POS = 4;

  // ==========================================================
  // Control code-groups.
  localparam logic [4:0] CG_IDLE = 5'h1F; // 11111
  localparam logic [4:0] CG_START1 = 5'h18; // 11000
  localparam logic [4:0] CG_START2 = 5'h11; // 10001
  localparam logic [4:0] CG_END1 = 5'h0D; // 01101
  localparam logic [4:0] CG_END2 = 5'h07; // 00111
  localparam logic [4:0] CG_HALT = 5'h04; // 00100

  // ==========================================================
  // Line timing: one serial bit slot every BIT_DIV core clocks.
  localparam int CORE_CLK_MHZ = 40;
  localparam int BIT_DIV = 2;
  localparam logic [1:0] BIT_CNT_LAST = 2'(BIT_DIV - 1);
  localparam logic [2:0] SYM_LAST_BIT = 3'h4;

  // ==========================================================
  // Scrambler seed and reset values.
  localparam logic [10:0] LFSR_RESET = 11'h7FF;
  localparam logic [6:0] SEED_LOW = 7'h7F;
  localparam logic [4:0] PIN_RESET = 5'h00;

  // ==========================================================
  // Transmit sequencing states.
  typedef enum logic [2:0] {
    FTE_ST_IDLE = 3'b000,
    FTE_ST_K = 3'b001,
    FTE_ST_DATA = 3'b010,
    FTE_ST_R = 3'b011
  } fte_state_e;

  // MLT-3 line levels.
  typedef enum logic [1:0] {
    FTE_MLT_ZERO_UP = 2'b00,
    FTE_MLT_POS = 2'b01,
    FTE_MLT_ZERO_DN = 2'b10,
    FTE_MLT_NEG = 2'b11
  } fte_mlt_e;

endpackage

// *** rtl/fte_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module fte_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  // Full when pointers differ only in the wrap bit.
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  // Storage write.
  always_ff @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Write pointer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
    end
  end

  // Read pointer.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_ptr_reg <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// *** rtl/fte_tx_encoder.sv ***
// Operation
// - Each transmit nibble maps to its fixed 5-bit data code-group.
// - Frame start sends 11000 then 10001 in place of two preamble nibbles.
// - When enable drops, send end pair 01101 then 00111.
// - Between frames send idle 11111 continuously.
// - Code-group 00100 is the halt (error) symbol.
// - Invalid, delimiter or idle code-groups inside a data field are flagged as errors.
// - Scrambler is a closed-loop 11-bit LFSR.
// - Each serial bit is XORed with the LFSR output.
// - Scrambler seed comes from port address bits 4 to 1.
// - A bypass input sends data past the scrambler unchanged.
// - Scrambled stream is NRZI coded, toggling on each one.
// - NRZI becomes two drive streams with alternating one events (MLT-3).
// - Line output is MLT-3 only; no plain binary mode exists.
// - Accepts 4-bit nibbles and produces the serial line stream.
// - Transmission follows the standard transmit state sequence.
`timescale 1ns/1ps
`default_nettype none

module fte_tx_encoder (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Nibble transmit side.
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  input wire logic [fte_pkg::NIB_W-1:0] mii_txd,
  output logic mii_tx_ready,
  // Configuration pins.
  input wire logic [4:0] port_address_pins,
  input wire logic scrambler_bypass,
  // Line side.
  output logic line_bit_en,
  output logic nrzi_out,
  output logic drive_pos,
  output logic drive_neg,
  // Status.
  output logic data_field_err
);

  import fte_pkg::*;

  // ==========================================================
  // Helper functions.

  // Maps a data nibble onto its code-group.
  function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
    logic [4:0] cg;
    cg = CG_IDLE;
    case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      4'hF: cg = 5'h1D;
      default: cg = CG_IDLE;
    endcase
    return cg;
  endfunction

  // True when a code-group may not stand in a data field: one of the
  // eight invalid groups or a delimiter or idle group.
  function automatic logic bad_in_data(input logic [4:0] cg);
    logic bad;
    bad = 1'b0;
    case (cg)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C: bad = 1'b1;
      CG_IDLE, CG_START1, CG_START2, CG_END1, CG_END2: bad = 1'b1;
      default: bad = 1'b0;
    endcase
    return bad;
  endfunction

  // Steps the MLT-3 level on a one event: zero, plus, zero, minus.
  function automatic fte_mlt_e mlt_step(input fte_mlt_e m);
    fte_mlt_e n;
    n = FTE_MLT_ZERO_UP;
    case (m)
      FTE_MLT_ZERO_UP: n = FTE_MLT_POS;
      FTE_MLT_POS: n = FTE_MLT_ZERO_DN;
      FTE_MLT_ZERO_DN: n = FTE_MLT_NEG;
      FTE_MLT_NEG: n = FTE_MLT_ZERO_UP;
      default: n = FTE_MLT_ZERO_UP;
    endcase
    return n;
  endfunction

  // ==========================================================
  // Input FIFO: a word is pushed while enable is high plus one end
  // marker with enable low, so the frame end travels in order.
  logic en_prev_reg;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;
  logic head_en;
  logic head_er;
  logic [3:0] head_nib;

  // Tracks enable so the falling edge produces the end marker.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_prev_reg <= 1'b0;
    end else if (fifo_in_ready) begin
      en_prev_reg <= mii_tx_en;
    end
  end

  assign fifo_in_valid = mii_tx_en || en_prev_reg;
  assign mii_tx_ready = fifo_in_ready;

  fte_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({mii_tx_er, mii_tx_en, mii_txd}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign head_er = fifo_out_data[WORD_ER_POS];
  assign head_en = fifo_out_data[WORD_EN_POS];
  assign head_nib = fifo_out_data[3:0];

  // ==========================================================
  // Pin synchronisers: three stages, a change is taken once the
  // second and third stages agree.
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [4:0] pin_s3_reg;
  logic [4:0] pin_filt_reg;

  // Synchroniser chain; it runs through reset so that the pins have
  // settled by the time the seed is taken after release.
  always_ff @(posedge core_clk) begin
    pin_s1_reg <= {scrambler_bypass, port_address_pins[4:1]};
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  // Filtered pin levels, also kept up to date during reset.
  always_ff @(posedge core_clk) begin
    if (pin_s2_reg == pin_s3_reg) begin
      pin_filt_reg <= pin_s3_reg;
    end
  end

  // ==========================================================
  // Bit-slot divider.
  logic [1:0] div_cnt_reg;
  logic bit_en;

  // Produces one enable pulse per line bit slot.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt_reg <= '0;
    end else if (div_cnt_reg == BIT_CNT_LAST) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  assign bit_en = (div_cnt_reg == BIT_CNT_LAST);

  // ==========================================================
  // Symbol sequencing.
  fte_state_e state_reg;
  fte_state_e state_next;
  logic [2:0] bit_idx_reg;
  logic [4:0] shift_reg;
  logic [4:0] cg_next;
  logic sym_load;
  logic pop_next;

  assign sym_load = bit_en && (bit_idx_reg == SYM_LAST_BIT);
  assign fifo_pop = sym_load && pop_next;

  // Chooses the next code-group and whether it consumes the FIFO head.
  always_comb begin
    state_next = state_reg;
    cg_next = CG_IDLE;
    pop_next = 1'b0;
    case (state_reg)
      FTE_ST_IDLE: begin
        if (fifo_out_valid) begin
          pop_next = 1'b1;
          if (head_en) begin
            cg_next = CG_START1;
            state_next = FTE_ST_K;
          end
        end
      end
      FTE_ST_K: begin
        cg_next = CG_START2;
        pop_next = fifo_out_valid && head_en;
        state_next = FTE_ST_DATA;
      end
      FTE_ST_DATA: begin
        if (!fifo_out_valid) begin
          cg_next = CG_HALT;
        end else if (!head_en) begin
          pop_next = 1'b1;
          cg_next = CG_END1;
          state_next = FTE_ST_R;
        end else begin
          pop_next = 1'b1;
          cg_next = head_er ? CG_HALT : encode_nibble(head_nib);
        end
      end
      FTE_ST_R: begin
        cg_next = CG_END2;
        state_next = FTE_ST_IDLE;
      end
      default: begin
        state_next = FTE_ST_IDLE;
      end
    endcase
  end

  // State advances once per code-group boundary.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= FTE_ST_IDLE;
    end else if (sym_load) begin
      state_reg <= state_next;
    end
  end

  // Serialiser: most significant code bit leaves first.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_idx_reg <= '0;
      shift_reg <= CG_IDLE;
    end else if (sym_load) begin
      bit_idx_reg <= '0;
      shift_reg <= cg_next;
    end else if (bit_en) begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      shift_reg <= {shift_reg[3:0], 1'b0};
    end
  end

  // Flags a code-group placed in a data field that is not legal there.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_field_err <= 1'b0;
    end else begin
      data_field_err <= sym_load && (state_reg == FTE_ST_DATA) && pop_next && head_en
        && bad_in_data(cg_next);
    end
  end

  // ==========================================================
  // Scrambler, closed loop with taps on stages 11 and 9.
  logic [10:0] lfsr_reg;
  logic seed_pending_reg;
  logic lfsr_out;
  logic scr_bit;

  assign lfsr_out = lfsr_reg[10] ^ lfsr_reg[8];
  assign scr_bit = pin_filt_reg[4] ? shift_reg[4] : (shift_reg[4] ^ lfsr_out);

  // Seed is loaded at the first bit slot after reset release.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seed_pending_reg <= 1'b1;
    end else if (!bit_en) begin
      seed_pending_reg <= seed_pending_reg;
    end else begin
      seed_pending_reg <= 1'b0;
    end
  end

  // LFSR advances one step per bit slot.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lfsr_reg <= LFSR_RESET;
    end else if (bit_en && seed_pending_reg) begin
      lfsr_reg <= {pin_filt_reg[3:0], SEED_LOW};
    end else if (bit_en) begin
      lfsr_reg <= {lfsr_reg[9:0], lfsr_out};
    end
  end

  // ==========================================================
  // NRZI and MLT-3 line coding; only the MLT-3 pair drives the line.
  fte_mlt_e mlt_reg;
  fte_mlt_e mlt_after;

  // NRZI level toggles on every one bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nrzi_out <= 1'b0;
    end else if (bit_en && scr_bit) begin
      nrzi_out <= !nrzi_out;
    end
  end

  // Level after this edge: each one event takes one step of the cycle.
  always_comb begin
    mlt_after = mlt_reg;
    if (bit_en && scr_bit) begin
      mlt_after = mlt_step(mlt_reg);
    end
  end

  // Each one event steps the line through zero, plus, zero, minus.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mlt_reg <= FTE_MLT_ZERO_UP;
    end else begin
      mlt_reg <= mlt_after;
    end
  end

  // Drive phases take the level after this edge, so they move together
  // with nrzi_out and the bit strobe instead of one cycle behind.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_pos <= 1'b0;
      drive_neg <= 1'b0;
      line_bit_en <= 1'b0;
    end else begin
      drive_pos <= (mlt_after == FTE_MLT_POS);
      drive_neg <= (mlt_after == FTE_MLT_NEG);
      line_bit_en <= bit_en;
    end
  end

endmodule

`default_nettype wire

// *** tb/fte_tx_encoder_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Line timing and MLT-3 checks at the encoder ports.
module fte_tx_encoder_props (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Watched outputs.
  input wire logic mii_tx_ready,
  input wire logic line_bit_en,
  input wire logic nrzi_out,
  input wire logic drive_pos,
  input wire logic drive_neg,
  input wire logic data_field_err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // The gap and the next pulse that follow a slot pulse.
  sequence s_next_slot;
    !line_bit_en ##1 line_bit_en;
  endsequence
  // A slot whose NRZI level differs from the previous slot.
  sequence s_toggle;
    line_bit_en && (nrzi_out != $past(nrzi_out, 2));
  endsequence
  property p_slot_rate;
    line_bit_en |=> s_next_slot;
  endproperty
  property p_stand;
    !line_bit_en |-> $stable(nrzi_out) && $stable(drive_pos) && $stable(drive_neg);
  endproperty
  property p_hold;
    line_bit_en && (nrzi_out == $past(nrzi_out, 2)) |->
      drive_pos == $past(drive_pos, 2) && drive_neg == $past(drive_neg, 2);
  endproperty
  property p_leave_pos;
    s_toggle ##0 $past(drive_pos, 2) |-> !drive_pos && !drive_neg;
  endproperty
  property p_leave_neg;
    s_toggle ##0 $past(drive_neg, 2) |-> !drive_pos && !drive_neg;
  endproperty
  property p_leave_zero;
    s_toggle ##0 (!$past(drive_pos, 2) && !$past(drive_neg, 2)) |-> drive_pos || drive_neg;
  endproperty
  property p_exclusive;
    !(drive_pos && drive_neg);
  endproperty
  property p_no_err;
    !data_field_err;
  endproperty
  property p_ready_back;
    $fell(mii_tx_ready) |-> ##[1:20] mii_tx_ready;
  endproperty
  property p_ready_reset;
    $fell(rst) |-> mii_tx_ready;
  endproperty
  a_slot_rate: assert property (p_slot_rate) else $error("slot spacing wrong");
  a_stand: assert property (p_stand) else $error("line moved off slot");
  a_hold: assert property (p_hold) else $error("drive moved without one");
  a_leave_pos: assert property (p_leave_pos) else $error("positive not left");
  a_leave_neg: assert property (p_leave_neg) else $error("negative not left");
  a_leave_zero: assert property (p_leave_zero) else $error("zero not left");
  a_exclusive: assert property (p_exclusive) else $error("both phases driven");
  a_no_err: assert property (p_no_err) else $error("illegal code-group chosen");
  a_ready_back: assert property (p_ready_back) else $error("fifo never drains");
  a_ready_reset: assert property (p_ready_reset) else $error("not ready after reset");
endmodule
bind fte_tx_encoder fte_tx_encoder_props u_props (.core_clk(core_clk), .rst(rst),
  .mii_tx_ready(mii_tx_ready), .line_bit_en(line_bit_en), .nrzi_out(nrzi_out),
  .drive_pos(drive_pos), .drive_neg(drive_neg), .data_field_err(data_field_err));
`default_nettype wire

// *** tb/fte_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Controller that hands nibbles to the encoder.
module fte_mac_model (
  // Clock and handshake.
  input wire logic core_clk,
  input wire logic ready,
  // Nibble outputs.
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] txd
);
  // Quiet lines until the first word.
  initial begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
  end
  // Holds one word until the edge that takes it.
  task automatic put(input logic en, input logic er, input logic [3:0] d);
    tx_en <= en;
    tx_er <= er;
    txd <= d;
    @(negedge core_clk);
    while (!ready) @(negedge core_clk);
    @(posedge core_clk);
  endtask
  // Idle nibble lines carry a changing pattern.
  task automatic rest(input int n);
    tx_en <= 1'b0;
    repeat (n) begin
      txd <= ~txd;
      @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/fast_ethernet_tx_encoder_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Frame traffic compared bit by bit against a line model.
module fast_ethernet_tx_encoder_test;
  import fte_pkg::*;
  localparam logic [79:0] CODES = {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic bypass = 1'b1;
  logic en, er, ready, bit_en, nrzi, dpos, dneg, ferr;
  logic [3:0] txd;
  logic [31:0] rng = 32'h0000_96BD;
  logic exp_q[$];
  int len_q[$];
  int n_errors = 0;
  int n_compared = 0;
  int slots, left;
  logic in_frame, last_nrzi, saw_full;
  logic bypass_mode = 1'b1;
  logic [10:0] key_reg;
  logic [10:0] seed_model;

  fte_tx_encoder dut (.core_clk(core_clk), .rst(rst), .mii_tx_en(en), .mii_tx_er(er),
    .mii_txd(txd), .mii_tx_ready(ready), .port_address_pins(addr), .scrambler_bypass(bypass),
    .line_bit_en(bit_en), .nrzi_out(nrzi), .drive_pos(dpos), .drive_neg(dneg),
    .data_field_err(ferr));
  fte_mac_model mac (.core_clk(core_clk), .ready(ready), .tx_en(en), .tx_er(er), .txd(txd));

  // Clock of 25 ns.
  always #12.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic check_key(input logic [10:0] got, input logic [10:0] want);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic add(input logic [4:0] cg);
    for (int i = 4; i >= 0; i--) exp_q.push_back(cg[i]);
  endtask

  // Sends one frame of n nibbles and queues its code bits.
  task automatic frame(input int n);
    logic [4:0] cg;
    logic e;
    len_q.push_back(5 * (n + 2));
    add(CG_START1);
    add(CG_START2);
    for (int i = 0; i < n; i++) begin
      rng = xs(rng);
      e = (i > 1) && (rng[7:5] == 3'h0);
      cg = e ? CG_HALT : CODES[5 * int'(rng[3:0]) +: 5];
      if (i > 1) add(cg);
      mac.put(1'b1, e, rng[3:0]);
    end
    add(CG_END1);
    add(CG_END2);
    mac.put(1'b0, 1'b0, ~rng[3:0]);
    mac.rest(int'(rng[12:8]) + 1);
  endtask

  task automatic drain();
    int w;
    w = 0;
    while ((len_q.size() > 0 || in_frame) && w < 5000) begin
      @(posedge core_clk);
      w++;
    end
    if (w == 5000) n_errors++;
    repeat (40) @(posedge core_clk);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Recovers code bits from the line at each slot and compares them from the 17th slot on.
  always @(negedge core_clk) begin : mon
    logic s, c, k;
    if (!ready) saw_full = 1'b1;
    if (rst) begin
      last_nrzi = 1'b0;
      slots = 0;
      in_frame = 1'b0;
      key_reg = 11'h000;
      seed_model = LFSR_RESET;
    end else if (bit_en) begin
      s = nrzi ^ last_nrzi;
      last_nrzi = nrzi;
      k = key_reg[10] ^ key_reg[8];
      c = bypass_mode ? s : s ^ k;
      key_reg = {key_reg[9:0], (slots < 16) ? ~s : k};
      if (slots == 0) seed_model = {addr[4:1], SEED_LOW};
      else seed_model = {seed_model[9:0], seed_model[10] ^ seed_model[8]};
      slots++;
      if (slots == 17 && !bypass_mode) check_key(key_reg, seed_model);
      if (slots > 16) begin
        if (!in_frame && c === 1'b0 && len_q.size() > 0) begin
          in_frame = 1'b1;
          left = len_q.pop_front() - 2;
          void'(exp_q.pop_front());
          void'(exp_q.pop_front());
        end
        if (in_frame) begin
          check(c, exp_q.pop_front());
          left--;
          if (left == 0) in_frame = 1'b0;
        end else begin
          check(c, 1'b1);
        end
      end
    end
  end

  // Bypassed run, then a scrambled run with a random address.
  initial begin
    saw_full = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    mac.rest(60);
    frame(40);
    for (int f = 0; f < 5; f++) frame(3 + int'(rng[20:16]));
    drain();
    rst <= 1'b1;
    bypass <= 1'b0;
    addr <= rng[4:0];
    bypass_mode = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    mac.rest(60);
    for (int f = 0; f < 6; f++) frame(3 + int'(rng[20:16]));
    drain();
    check(saw_full, 1'b1);
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
